// File: logic/aifs_pkg.sv
// Package for the analog input fault and status reporting block.
// Assumes a single 200 MHz core clock and a plain register port.
package aifs_pkg;
  localparam int NUM_CH = 6;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte offsets; condition word n sits at OFF_COND0 + 4*n
  localparam logic [7:0] OFF_SUMMARY = 8'h00;
  localparam logic [7:0] OFF_LANE_ERR = 8'h04;
  localparam logic [7:0] OFF_COND0 = 8'h08;
  localparam logic [7:0] OFF_IRQ_STS = 8'h20;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h24;
  localparam logic [7:0] OFF_CTRL = 8'h28;
  // Summary word fields
  localparam int SUM_ANALOG_GRP_BIT = 15;
  localparam int SUM_INPUT_GRP_BIT = 14;
  localparam int SUM_CALIBRATING_BIT = 12;
  localparam int SUM_CAL_ERR_BIT = 11;
  // Condition word fields
  localparam int COND_CAL_ERR_BIT = 7;
  localparam int COND_UNDER_BIT = 6;
  localparam int COND_OVER_BIT = 5;
  localparam int COND_RATE_BIT = 4;
  localparam int COND_LOW_BIT = 3;
  localparam int COND_HIGH_BIT = 2;
  localparam int COND_LOWLOW_BIT = 1;
  localparam int COND_HIGHHIGH_BIT = 0;
  // Forced lane error values
  localparam logic [15:0] LANE_ERR_CAL = 16'h003F;
  localparam logic [15:0] LANE_ERR_COMM = 16'hFFFF;
  // Interrupt status bits
  localparam int IRQ_W = 4;
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_CAL_ERR_BIT = 1;
  localparam int IRQ_COMM_BIT = 2;
  localparam int IRQ_OVERRUN_BIT = 3;
  // Reset values
  localparam logic [3:0] IRQ_MSK_RST = 4'h0;
  localparam logic [5:0] CTRL_RST = 6'h3F;
  // Frame: summary, lane error, six condition words, six data words
  localparam int FRAME_LEN = 14;
  localparam logic [3:0] FRAME_LAST = 4'hD;
  localparam logic [1:0] DEST_OWNER_LISTENERS = 2'h3;
  typedef enum logic [1:0] {
    AIFS_IDLE = 2'b01,
    AIFS_SEND = 2'b10
  } aifs_state_t;
endpackage

// File: logic/aifs_top.sv
// Fault and status reporting for a six-channel analog input unit.
// Assumes channel conditions and the update strobe are synchronous to
// CORE_CLK_I and that the register master follows the plain strobe port.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
module aifs_top
  import aifs_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  // Register port
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WR_DATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [DATA_W-1:0] RD_DATA_O,
  // Interrupt
  output logic IRQ_O,
  // Channel conditions, one bit per channel, plus one unit-wide comm failure bit
  input wire logic [NUM_CH-1:0] CH_UNDER_I,
  input wire logic [NUM_CH-1:0] CH_OVER_I,
  input wire logic [NUM_CH-1:0] CH_HIGHHIGH_I,
  input wire logic [NUM_CH-1:0] CH_LOWLOW_I,
  input wire logic [NUM_CH-1:0] CH_HIGH_I,
  input wire logic [NUM_CH-1:0] CH_LOW_I,
  input wire logic [NUM_CH-1:0] CH_RATE_I,
  input wire logic [NUM_CH-1:0] CH_CAL_ERR_I,
  input wire logic [NUM_CH-1:0] CH_CALIBRATING_I,
  input wire logic COMM_FAIL_I,
  // Channel data update
  input wire logic UPDATE_I,
  input wire logic [NUM_CH*WORD_W-1:0] CH_DATA_I,
  // Outgoing report stream
  output logic TX_VALID_O,
  output logic [WORD_W-1:0] TX_WORD_O,
  output logic TX_FIRST_O,
  output logic TX_LAST_O,
  output logic [1:0] TX_DEST_O
);

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // Summary word shows a fault somewhere on the unit
  function automatic logic fault_seen(input logic [WORD_W-1:0] w);
    fault_seen = (w != '0);
  endfunction

  // Lane word carries the communication-failure pattern
  function automatic logic comm_lost(input logic [WORD_W-1:0] w);
    comm_lost = (w == LANE_ERR_COMM);
  endfunction

  // Per-channel condition words
  logic [WORD_W-1:0] cond_w [NUM_CH];
  logic [NUM_CH-1:0] ctrl_q;
  logic [NUM_CH-1:0] range_w;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_cond
      // Disabled channels report no range or alarm, cal error still shows
      logic en;
      assign en = ctrl_q[g];
      assign range_w[g] = en & (CH_UNDER_I[g] | CH_OVER_I[g]);
      assign cond_w[g] = {8'h00,
                          CH_CAL_ERR_I[g],
                          en & CH_UNDER_I[g],
                          en & CH_OVER_I[g],
                          en & CH_RATE_I[g],
                          en & CH_LOW_I[g],
                          en & CH_HIGH_I[g],
                          en & CH_LOWLOW_I[g],
                          en & CH_HIGHHIGH_I[g]};
    end
  endgenerate

  // Fault hierarchy
  logic [WORD_W-1:0] lane_err_d, lane_err_q;
  logic [WORD_W-1:0] summary_d, summary_q;
  logic [WORD_W-1:0] cond_d [NUM_CH];
  logic [WORD_W-1:0] cond_q [NUM_CH];

  always_comb begin
    logic cal_any;
    logic err_any;
    cal_any = |CH_CALIBRATING_I;
    err_any = 1'b0;
    if (COMM_FAIL_I) begin
      lane_err_d = LANE_ERR_COMM;
    end else if (cal_any) begin
      lane_err_d = LANE_ERR_CAL;
    end else begin
      lane_err_d = '0;
      lane_err_d[NUM_CH-1:0] = range_w;
    end
    err_any = |lane_err_d;
    summary_d = '0;
    summary_d[SUM_ANALOG_GRP_BIT] = err_any;
    summary_d[SUM_INPUT_GRP_BIT] = err_any;
    summary_d[SUM_CALIBRATING_BIT] = cal_any;
    summary_d[SUM_CAL_ERR_BIT] = |CH_CAL_ERR_I;
    for (int i = 0; i < NUM_CH; i++) begin
      cond_d[i] = cond_w[i];
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      lane_err_q <= '0;
      summary_q <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        cond_q[i] <= '0;
      end
    end else begin
      lane_err_q <= lane_err_d;
      summary_q <= summary_d;
      for (int i = 0; i < NUM_CH; i++) begin
        cond_q[i] <= cond_d[i];
      end
    end
  end

  // Report frame sequencer
  aifs_state_t state_d, state_q;
  logic [3:0] idx_d, idx_q;
  logic [WORD_W-1:0] frame_d [FRAME_LEN];
  logic [WORD_W-1:0] frame_q [FRAME_LEN];
  logic tx_valid_d, tx_first_d, tx_last_d;
  logic [WORD_W-1:0] tx_word_d;
  logic overrun;

  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    overrun = 1'b0;
    tx_valid_d = 1'b0;
    tx_first_d = 1'b0;
    tx_last_d = 1'b0;
    tx_word_d = '0;
    for (int i = 0; i < FRAME_LEN; i++) begin
      frame_d[i] = frame_q[i];
    end
    case (state_q)
      AIFS_IDLE: begin
        if (UPDATE_I) begin
          // Snapshot so the frame is self-consistent while it goes out
          frame_d[0] = summary_q;
          frame_d[1] = lane_err_q;
          for (int i = 0; i < NUM_CH; i++) begin
            frame_d[2+i] = cond_q[i];
            frame_d[2+NUM_CH+i] = CH_DATA_I[i*WORD_W +: WORD_W];
          end
          idx_d = 4'h0;
          state_d = AIFS_SEND;
        end
      end
      AIFS_SEND: begin
        // An update during a frame is dropped and flagged, not queued
        overrun = UPDATE_I;
        tx_valid_d = 1'b1;
        tx_first_d = (idx_q == 4'h0);
        tx_last_d = (idx_q == FRAME_LAST);
        tx_word_d = frame_q[idx_q];
        if (idx_q == FRAME_LAST) begin
          state_d = AIFS_IDLE;
        end else begin
          idx_d = 4'(idx_q + 4'h1);
        end
      end
      default: begin
        state_d = AIFS_IDLE;
        idx_d = 4'h0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      state_q <= AIFS_IDLE;
      idx_q <= 4'h0;
      TX_VALID_O <= 1'b0;
      TX_FIRST_O <= 1'b0;
      TX_LAST_O <= 1'b0;
      TX_WORD_O <= '0;
      TX_DEST_O <= DEST_OWNER_LISTENERS;
      for (int i = 0; i < FRAME_LEN; i++) begin
        frame_q[i] <= '0;
      end
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      TX_VALID_O <= tx_valid_d;
      TX_FIRST_O <= tx_first_d;
      TX_LAST_O <= tx_last_d;
      TX_WORD_O <= tx_word_d;
      TX_DEST_O <= DEST_OWNER_LISTENERS;
      for (int i = 0; i < FRAME_LEN; i++) begin
        frame_q[i] <= frame_d[i];
      end
    end
  end

  // Interrupt sources: rising edges of fault, cal error and comm loss, plus frame overrun
  logic [IRQ_W-1:0] irq_sts_d, irq_sts_q;
  logic [IRQ_W-1:0] irq_msk_d, irq_msk_q;
  logic [NUM_CH-1:0] ctrl_d;
  logic fault_prev_q, cal_prev_q, comm_prev_q;
  logic irq_d;
  logic [DATA_W-1:0] rd_data_d;

  always_comb begin
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    ev = '0;
    clr = '0;
    ev[IRQ_FAULT_BIT] = fault_seen(summary_q) & ~fault_prev_q;
    ev[IRQ_CAL_ERR_BIT] = summary_q[SUM_CAL_ERR_BIT] & ~cal_prev_q;
    ev[IRQ_COMM_BIT] = comm_lost(lane_err_q) & ~comm_prev_q;
    ev[IRQ_OVERRUN_BIT] = overrun;
    irq_msk_d = irq_msk_q;
    ctrl_d = ctrl_q;
    if (WR_I) begin
      if (hit(ADDR_I, OFF_IRQ_STS)) begin
        clr = WR_DATA_I[IRQ_W-1:0];
      end
      if (hit(ADDR_I, OFF_IRQ_MSK)) begin
        irq_msk_d = WR_DATA_I[IRQ_W-1:0];
      end
      if (hit(ADDR_I, OFF_CTRL)) begin
        ctrl_d = WR_DATA_I[NUM_CH-1:0];
      end
    end
    // A new event beats a clear in the same cycle
    irq_sts_d = (irq_sts_q & ~clr) | ev;
    irq_d = |(irq_sts_d & irq_msk_d);
    rd_data_d = '0;
    if (RD_I) begin
      if (hit(ADDR_I, OFF_SUMMARY)) begin
        rd_data_d[WORD_W-1:0] = summary_q;
      end
      if (hit(ADDR_I, OFF_LANE_ERR)) begin
        rd_data_d[WORD_W-1:0] = lane_err_q;
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (hit(ADDR_I, 8'(OFF_COND0 + 8'(4*i)))) begin
          rd_data_d[WORD_W-1:0] = cond_q[i];
        end
      end
      if (hit(ADDR_I, OFF_IRQ_STS)) begin
        rd_data_d[IRQ_W-1:0] = irq_sts_q;
      end
      if (hit(ADDR_I, OFF_IRQ_MSK)) begin
        rd_data_d[IRQ_W-1:0] = irq_msk_q;
      end
      if (hit(ADDR_I, OFF_CTRL)) begin
        rd_data_d[NUM_CH-1:0] = ctrl_q;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      irq_sts_q <= '0;
      irq_msk_q <= IRQ_MSK_RST;
      ctrl_q <= CTRL_RST;
      fault_prev_q <= 1'b0;
      cal_prev_q <= 1'b0;
      comm_prev_q <= 1'b0;
      IRQ_O <= 1'b0;
      RD_DATA_O <= '0;
    end else begin
      irq_sts_q <= irq_sts_d;
      irq_msk_q <= irq_msk_d;
      ctrl_q <= ctrl_d;
      fault_prev_q <= fault_seen(summary_q);
      cal_prev_q <= summary_q[SUM_CAL_ERR_BIT];
      comm_prev_q <= comm_lost(lane_err_q);
      IRQ_O <= irq_d;
      RD_DATA_O <= rd_data_d;
    end
  end

endmodule // aifs_top

// File: tb/aifs_checker.sv
// Assertions on the ports of the fault reporting block.
// Assumes fault inputs hold steady from four cycles before an update.
`timescale 1ns/100ps
module aifs_checker
  import aifs_pkg::*;
(
  // Watched ports
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic [NUM_CH-1:0] CH_CAL_ERR_I,
  input wire logic [NUM_CH-1:0] CH_CALIBRATING_I,
  input wire logic COMM_FAIL_I,
  input wire logic UPDATE_I,
  input wire logic IRQ_O,
  input wire logic TX_VALID_O,
  input wire logic [WORD_W-1:0] TX_WORD_O,
  input wire logic TX_FIRST_O,
  input wire logic TX_LAST_O,
  input wire logic [1:0] TX_DEST_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);
  // Short input history, so forcing is judged only on settled inputs
  logic [3:0] cm_q, ca_q, ce_q;
  always_ff @(posedge CORE_CLK_I) begin
    cm_q <= {cm_q[2:0], COMM_FAIL_I};
    ca_q <= {ca_q[2:0], |CH_CALIBRATING_I};
    ce_q <= {ce_q[2:0], |CH_CAL_ERR_I};
  end
  a_dest_all: assert property (TX_DEST_O == 2'h3)
    else $error("Frame not addressed to all controllers");
  a_frame_span: assert property (TX_FIRST_O |-> TX_VALID_O ##13 TX_LAST_O)
    else $error("Frame length wrong");
  a_update_start: assert property ($rose(TX_VALID_O) |-> $past(UPDATE_I, 2))
    else $error("Frame without update");
  a_group_bit: assert property (TX_FIRST_O |=> (|TX_WORD_O) == $past(TX_WORD_O[15]))
    else $error("Analog group bit wrong");
  a_input_bit: assert property (TX_FIRST_O |=> (|TX_WORD_O) == $past(TX_WORD_O[14]))
    else $error("Input collection bit wrong");
  a_comm_all: assert property (TX_FIRST_O && &cm_q |=> TX_WORD_O == 16'hFFFF)
    else $error("Lane word not forced on comm fail");
  a_cal_force: assert property (TX_FIRST_O && &ca_q && ~|cm_q |-> TX_WORD_O[12] ##1 TX_WORD_O == 16'h003F)
    else $error("Calibration forcing wrong");
  a_cal_error: assert property (TX_FIRST_O && &ce_q |-> TX_WORD_O[11])
    else $error("Calibration error bit missing");
  a_lane_clear: assert property (TX_FIRST_O && ~|ca_q && ~|cm_q |=> TX_WORD_O[15:6] == 10'h000)
    else $error("Lane word upper bits set");
  cover property (TX_FIRST_O && &cm_q);
  cover property (TX_FIRST_O && &ca_q);
  cover property (IRQ_O);
endmodule // aifs_checker

bind aifs_top aifs_checker u_chk (.CORE_CLK_I, .SRST_I, .CH_CAL_ERR_I,
  .CH_CALIBRATING_I, .COMM_FAIL_I, .UPDATE_I, .IRQ_O, .TX_VALID_O,
  .TX_WORD_O, .TX_FIRST_O, .TX_LAST_O, .TX_DEST_O);

// File: tb/aifs_sink.sv
// Model of the owner controller collecting report frames.
// Assumes one word a cycle while valid is high, first word flagged.
`timescale 1ns/100ps
module aifs_sink
  import aifs_pkg::*;
(
  // Report stream
  input wire logic clk_i,
  input wire logic valid_i,
  input wire logic first_i,
  input wire logic [1:0] dest_i,
  input wire logic [WORD_W-1:0] word_i,
  // Collected frame
  output logic [WORD_W-1:0] rx_o [FRAME_LEN],
  output int frames_o
);
  int idx = 0;
  initial frames_o = 0;
  // Listeners see the same words, so one copy serves them all
  always @(posedge clk_i) begin
    if (valid_i && dest_i == DEST_OWNER_LISTENERS) begin
      idx = first_i ? 0 : idx + 1;
      if (idx < FRAME_LEN) rx_o[idx] <= word_i;
      if (idx == FRAME_LEN - 1) frames_o <= frames_o + 1;
    end
  end
endmodule // aifs_sink

// File: tb/aifs_tb_top.sv
// Self-checking bench for the fault reporting block.
// Assumes the block reports through registers and the frame stream.
`timescale 1ns/100ps
module aifs_tb_top
  import aifs_pkg::*;
;
  typedef struct packed {
    logic [5:0] u, o, ca, ce;
    logic cm;
    logic [31:0] sum, lane;
    logic [7:0] ca_addr;
    logic [31:0] cexp;
  } aifs_vec_t;
  logic clk = 0, rst = 1, wr = 0, rd = 0, comm = 0, upd = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0, rdata;
  logic [5:0] un = '0, ov = '0, hh = '0, ll = '0, hi = '0, lo = '0;
  logic [5:0] rt = '0, ce = '0, cl = '0;
  logic [95:0] dat = '0;
  logic irq, tv, tf, tl;
  logic [15:0] tw;
  logic [1:0] td;
  logic [15:0] rx [FRAME_LEN];
  int frames, error_cnt = 0, checks_done = 0, cyc = 0, frm = 0;
  aifs_vec_t vec [8] = '{
    '{6'h00, 6'h00, 6'h00, 6'h00, 1'b0, 32'h0, 32'h0, 8'h08, 32'h00},
    '{6'h01, 6'h00, 6'h00, 6'h00, 1'b0, 32'hC000, 32'h1, 8'h08, 32'h40},
    '{6'h00, 6'h20, 6'h00, 6'h00, 1'b0, 32'hC000, 32'h20, 8'h1C, 32'h20},
    '{6'h04, 6'h08, 6'h00, 6'h00, 1'b0, 32'hC000, 32'hC, 8'h10, 32'h40},
    '{6'h00, 6'h00, 6'h02, 6'h00, 1'b0, 32'hD000, 32'h3F, 8'h0C, 32'h00},
    '{6'h00, 6'h00, 6'h00, 6'h10, 1'b0, 32'h0800, 32'h0, 8'h18, 32'h80},
    '{6'h01, 6'h00, 6'h00, 6'h00, 1'b1, 32'hC000, 32'hFFFF, 8'h08, 32'h40},
    '{6'h00, 6'h00, 6'h02, 6'h00, 1'b1, 32'hD000, 32'hFFFF, 8'h0C, 32'h00}
  };
  always #2.5 clk = ~clk;
  aifs_top dut (.CORE_CLK_I(clk), .SRST_I(rst), .ADDR_I(addr),
    .WR_DATA_I(wd), .WR_I(wr), .RD_I(rd), .RD_DATA_O(rdata), .IRQ_O(irq),
    .CH_UNDER_I(un), .CH_OVER_I(ov), .CH_HIGHHIGH_I(hh), .CH_LOWLOW_I(ll),
    .CH_HIGH_I(hi), .CH_LOW_I(lo), .CH_RATE_I(rt), .CH_CAL_ERR_I(ce),
    .CH_CALIBRATING_I(cl), .COMM_FAIL_I(comm), .UPDATE_I(upd),
    .CH_DATA_I(dat), .TX_VALID_O(tv), .TX_WORD_O(tw), .TX_FIRST_O(tf),
    .TX_LAST_O(tl), .TX_DEST_O(td));
  aifs_sink u_sink (.clk_i(clk), .valid_i(tv), .first_i(tf), .dest_i(td),
    .word_i(tw), .rx_o(rx), .frames_o(frames));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic send();
    int n;
    n = frames;
    @(posedge clk);
    upd <= 1'b1;
    @(posedge clk);
    upd <= 1'b0;
    for (int i = 0; i < 30 && frames == n; i++) @(posedge clk);
    #1 chk(frames, n + 1);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdc(OFF_SUMMARY, 32'h0);
    rdc(OFF_CTRL, 32'h3F);
    foreach (vec[i]) begin
      @(posedge clk);
      un <= vec[i].u;
      ov <= vec[i].o;
      cl <= vec[i].ca;
      ce <= vec[i].ce;
      comm <= vec[i].cm;
      dat <= {6{vec[i].sum[15:0] ^ 16'h5A5A}};
      repeat (4) @(posedge clk);
      rdc(OFF_SUMMARY, vec[i].sum);
      rdc(OFF_LANE_ERR, vec[i].lane);
      rdc(vec[i].ca_addr, vec[i].cexp);
      send();
      chk(32'(rx[0]), vec[i].sum);
      chk(32'(rx[1]), vec[i].lane);
      chk(32'(rx[13]), 32'(vec[i].sum[15:0] ^ 16'h5A5A));
    end
    @(posedge clk);
    un <= '0;
    cl <= '0;
    comm <= 1'b0;
    ce <= '0;
    hh <= 6'h02;
    ll <= 6'h02;
    hi <= 6'h02;
    lo <= 6'h02;
    rt <= 6'h02;
    repeat (4) @(posedge clk);
    rdc(8'h0C, 32'h1F);
    #1 chk({31'h0, irq}, 32'h0);
    rdc(OFF_IRQ_STS, 32'h7);
    wrc(OFF_IRQ_MSK, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h1);
    wrc(OFF_IRQ_STS, 32'h7);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0);
    // Disabled lane hides its range bits; read-only words ignore writes
    wrc(OFF_CTRL, 32'h3D);
    un <= 6'h02;
    wrc(OFF_LANE_ERR, 32'hFFFF);
    repeat (4) @(posedge clk);
    rdc(OFF_LANE_ERR, 32'h0);
    rdc(8'h0C, 32'h0);
    rdc(8'hFC, 32'h0);
    // An update while a frame is busy is dropped and flagged
    wrc(OFF_IRQ_STS, 32'hF);
    frm = frames;
    @(posedge clk);
    upd <= 1'b1;
    @(posedge clk);
    upd <= 1'b0;
    repeat (4) @(posedge clk);
    upd <= 1'b1;
    @(posedge clk);
    upd <= 1'b0;
    repeat (30) @(posedge clk);
    #1 chk(frames, frm + 1);
    rdc(OFF_IRQ_STS, 32'h8);
    @(posedge clk);
    un <= '0;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdc(OFF_CTRL, 32'h3F);
    rdc(OFF_IRQ_MSK, 32'h0);
    rdc(OFF_IRQ_STS, 32'h0);
    complete_run();
  end
endmodule // aifs_tb_top
